// >>> hw/csh_pkg.sv
// Constants and types shared by the combined serial halt/push controller.
// Assumes a single system clock; all users reference names with csh_pkg::.
package csh_pkg;
    localparam int FRAME_BITS = 16;
    // Delay-after-transfer length, in baud clock periods.
    localparam int DAT_BAUDS = 2;
    // Settling interval a host may wait after requesting a halt.
    localparam int HALT_WAIT_BAUDS = 35;
    localparam int BUF_DEPTH = 2;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] DAT_CNT_ZERO = 4'h0;

    typedef enum logic [1:0] {
        CSH_MODE_COMBINED = 2'h0,
        CSH_MODE_DSI_ONLY = 2'h1,
        CSH_MODE_SPI_ONLY = 2'h2
    } csh_mode_t;

    typedef enum logic [2:0] {
        CSH_ST_IDLE = 3'b001,
        CSH_ST_XFER = 3'b010,
        CSH_ST_DAT = 3'b100
    } csh_state_t;
endpackage : csh_pkg

// >>> hw/csh_stream_if.sv
// Valid/ready word stream between the controller and its frame buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface csh_stream_if #(
    parameter int W = 16
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : csh_stream_if

// >>> hw/csh_frame_buf.sv
// Two-entry frame buffer with valid/ready on both sides.
// Assumes the drain side may stall at will; the fill ready is registered.
`timescale 1ns/100ps
module csh_frame_buf #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Streams
    csh_stream_if.snk in_s,
    csh_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic ready_r, ready_nxt;
    logic push, pop;

    function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
        inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : inc_ptr

    assign in_s.ready = ready_r;
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data = mem_r[rd_r];

    always_comb begin
        push = in_s.valid && ready_r;
        pop = out_s.valid && out_s.ready;
        wr_nxt = push ? inc_ptr(wr_r) : wr_r;
        rd_nxt = pop ? inc_ptr(rd_r) : rd_r;
        cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
        ready_nxt = (cnt_nxt != CNT_FULL);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
        end
    end

    // Storage carries no reset; a slot is only read once it was written.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_s.data;
        end
    end
endmodule : csh_frame_buf

// >>> hw/csh_ctrl.sv
// Combined serial controller: periodic deserial frames interleaved with
// host-queued SPI frames, halt control, and transfer-complete request.
// Assumes host-side controls are on sys_clk; baud clock and miso are not.
`timescale 1ns/100ps
module csh_ctrl #(
    parameter int W = csh_pkg::FRAME_BITS,
    parameter int DAT_BAUDS = csh_pkg::DAT_BAUDS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Push transmit queue
    input wire logic push_wr,
    input wire logic [W-1:0] push_data,
    output logic push_ready,
    // Configuration
    input wire logic [1:0] mode,
    input wire logic halt,
    input wire logic tc_irq_en,
    input wire logic [W-1:0] dsi_data,
    // Status
    input wire logic tc_clr,
    output logic running,
    output logic tc_flag,
    output logic tc_irq,
    output logic [W-1:0] rx_data,
    output logic rx_valid,
    // Serial link
    input wire logic baud_clk,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic spi_cs_n,
    output logic dsi_cs_n
);
    localparam logic [3:0] BIT_LAST = 4'(W - 1);
    localparam logic [3:0] DAT_LAST = 4'(DAT_BAUDS - 1);

    csh_stream_if #(.W(W)) in_s ();
    csh_stream_if #(.W(W)) out_s ();

    csh_frame_buf #(.W(W), .DEPTH(csh_pkg::BUF_DEPTH)) u_buf (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_s(in_s),
        .out_s(out_s)
    );

    // Pin synchronisers; the first stage feeds only the second.
    logic baud_s1_r, baud_s2_r, baud_d_r, miso_s1_r, miso_s2_r;
    logic tick;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            baud_s1_r <= 1'b0;
            baud_s2_r <= 1'b0;
            baud_d_r <= 1'b0;
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            baud_s1_r <= baud_clk;
            baud_s2_r <= baud_s1_r;
            baud_d_r <= baud_s2_r;
            miso_s1_r <= miso;
            miso_s2_r <= miso_s1_r;
        end
    end

    assign tick = baud_s2_r && !baud_d_r;

    assign in_s.valid = push_wr;
    assign in_s.data = push_data;

    csh_pkg::csh_state_t state_r, state_nxt;
    logic [W-1:0] tx_r, tx_nxt, rxsh_r, rxsh_nxt;
    logic [W-1:0] rx_data_r, rx_data_nxt;
    logic [3:0] bit_r, bit_nxt, dat_r, dat_nxt;
    logic sck_r, sck_nxt, mosi_r, mosi_nxt;
    // Selects are kept active low in their flops so the pins come straight
    // from a register with no inverter after it.
    logic spi_cs_n_r, spi_cs_n_nxt, dsi_cs_n_r, dsi_cs_n_nxt;
    logic run_r, run_nxt, tcf_r, tcf_nxt, irq_r, irq_nxt;
    logic rxv_r, rxv_nxt, pick_spi, pick_dsi, frame_end, take;

    always_comb begin
        state_nxt = state_r;
        tx_nxt = tx_r;
        rxsh_nxt = rxsh_r;
        rx_data_nxt = rx_data_r;
        bit_nxt = bit_r;
        dat_nxt = dat_r;
        sck_nxt = sck_r;
        mosi_nxt = mosi_r;
        spi_cs_n_nxt = spi_cs_n_r;
        dsi_cs_n_nxt = dsi_cs_n_r;
        rxv_nxt = 1'b0;
        frame_end = 1'b0;
        // Frames are chosen only from idle, so a push never lands mid-frame.
        pick_spi = 1'b0;
        pick_dsi = 1'b0;
        take = 1'b0;
        if (mode == csh_pkg::CSH_MODE_SPI_ONLY) begin
            pick_spi = out_s.valid;
        end else if (mode == csh_pkg::CSH_MODE_DSI_ONLY) begin
            pick_dsi = 1'b1;
        end else begin
            // Queued SPI words take the next slot; otherwise deserial repeats.
            pick_spi = out_s.valid;
            pick_dsi = !out_s.valid;
        end
        unique case (state_r)
            csh_pkg::CSH_ST_IDLE: begin
                // Halt is honoured only here, after a frame has completed.
                if (tick && !halt && (pick_spi || pick_dsi)) begin
                    take = pick_spi;
                    tx_nxt = pick_spi ? out_s.data : dsi_data;
                    mosi_nxt = pick_spi ? out_s.data[W-1] : dsi_data[W-1];
                    spi_cs_n_nxt = !pick_spi;
                    dsi_cs_n_nxt = pick_spi;
                    bit_nxt = csh_pkg::BIT_CNT_ZERO;
                    state_nxt = csh_pkg::CSH_ST_XFER;
                end
            end
            csh_pkg::CSH_ST_XFER: begin
                if (tick) begin
                    sck_nxt = !sck_r;
                    if (!sck_r) begin
                        rxsh_nxt = {rxsh_r[W-2:0], miso_s2_r};
                    end else if (bit_r == BIT_LAST) begin
                        frame_end = 1'b1;
                        rx_data_nxt = rxsh_r;
                        rxv_nxt = 1'b1;
                        spi_cs_n_nxt = 1'b1;
                        dsi_cs_n_nxt = 1'b1;
                        dat_nxt = csh_pkg::DAT_CNT_ZERO;
                        state_nxt = csh_pkg::CSH_ST_DAT;
                    end else begin
                        tx_nxt = {tx_r[W-2:0], 1'b0};
                        mosi_nxt = tx_r[W-2];
                        bit_nxt = bit_r + 4'h1;
                    end
                end
            end
            csh_pkg::CSH_ST_DAT: begin
                if (tick) begin
                    if (dat_r == DAT_LAST) begin
                        state_nxt = csh_pkg::CSH_ST_IDLE;
                    end else begin
                        dat_nxt = dat_r + 4'h1;
                    end
                end
            end
            default: begin
                state_nxt = csh_pkg::CSH_ST_IDLE;
            end
        endcase
        // Running clears only once idle with halt pending.
        run_nxt = !(state_nxt == csh_pkg::CSH_ST_IDLE && halt);
        // A frame end in the same cycle as a clear keeps the flag set.
        tcf_nxt = frame_end || (tcf_r && !tc_clr);
        irq_nxt = tcf_nxt && tc_irq_en;
    end

    assign out_s.ready = take;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= csh_pkg::CSH_ST_IDLE;
            tx_r <= '0;
            rxsh_r <= '0;
            rx_data_r <= '0;
            bit_r <= csh_pkg::BIT_CNT_ZERO;
            dat_r <= csh_pkg::DAT_CNT_ZERO;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
            spi_cs_n_r <= 1'b1;
            dsi_cs_n_r <= 1'b1;
            run_r <= 1'b0;
            tcf_r <= 1'b0;
            irq_r <= 1'b0;
            rxv_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tx_r <= tx_nxt;
            rxsh_r <= rxsh_nxt;
            rx_data_r <= rx_data_nxt;
            bit_r <= bit_nxt;
            dat_r <= dat_nxt;
            sck_r <= sck_nxt;
            mosi_r <= mosi_nxt;
            spi_cs_n_r <= spi_cs_n_nxt;
            dsi_cs_n_r <= dsi_cs_n_nxt;
            run_r <= run_nxt;
            tcf_r <= tcf_nxt;
            irq_r <= irq_nxt;
            rxv_r <= rxv_nxt;
        end
    end

    assign push_ready = in_s.ready;
    assign running = run_r;
    assign tc_flag = tcf_r;
    assign tc_irq = irq_r;
    assign rx_data = rx_data_r;
    assign rx_valid = rxv_r;
    assign sck = sck_r;
    assign mosi = mosi_r;
    assign spi_cs_n = spi_cs_n_r;
    assign dsi_cs_n = dsi_cs_n_r;
endmodule : csh_ctrl

// >>> test/csh_props.sv
// Concurrent checks on the combined serial controller ports.
// Assumes it is bound into csh_ctrl and sees only its ports.
`timescale 1ns/100ps
module csh_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Host side
    input wire logic push_wr,
    input wire logic push_ready,
    input wire logic halt,
    input wire logic tc_irq_en,
    input wire logic running,
    input wire logic tc_flag,
    input wire logic tc_irq,
    input wire logic rx_valid,
    // Link side
    input wire logic sck,
    input wire logic spi_cs_n,
    input wire logic dsi_cs_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_idle; spi_cs_n && dsi_cs_n; endsequence
    property p_one_sel; !(!spi_cs_n && !dsi_cs_n); endproperty
    property p_sck_idle; s_idle |-> !sck; endproperty
    property p_halted; !running |-> s_idle; endproperty
    property p_fell_run;
        $fell(running) |-> $past(spi_cs_n) && $past(dsi_cs_n);
    endproperty
    property p_resume; !halt && !running |-> ##[1:3] running; endproperty
    property p_irq; $rose(tc_flag) |-> tc_irq == $past(tc_irq_en); endproperty
    property p_rx_flag; rx_valid |-> tc_flag ##1 !rx_valid; endproperty
    // Only a push can fill the buffer, so a fall needs a recent push.
    property p_push_fell;
        $fell(push_ready) |-> $past(push_wr) || $past(push_wr, 2);
    endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("both frame selects low");
    a_sck_idle: assert property (p_sck_idle)
        else $error("serial clock high outside a frame");
    a_halted: assert property (p_halted)
        else $error("frame active while halted");
    a_fell_run: assert property (p_fell_run)
        else $error("halted before frame finished");
    a_resume: assert property (p_resume)
        else $error("no resume after halt cleared");
    a_irq: assert property (p_irq)
        else $error("request does not follow complete flag");
    a_rx_flag: assert property (p_rx_flag)
        else $error("receive pulse without complete flag");
    a_push_fell: assert property (p_push_fell)
        else $error("push ready fell without a push");
endmodule : csh_props

bind csh_ctrl csh_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .push_wr(push_wr), .push_ready(push_ready), .halt(halt),
    .tc_irq_en(tc_irq_en), .running(running), .tc_flag(tc_flag),
    .tc_irq(tc_irq), .rx_valid(rx_valid), .sck(sck),
    .spi_cs_n(spi_cs_n), .dsi_cs_n(dsi_cs_n));

// >>> test/csh_periph.sv
// Serial peripheral model answering on miso while either select is low.
// Assumes data may change on the falling serial clock, MSB first.
`timescale 1ns/100ps
module csh_periph #(
    parameter logic [15:0] ANSWER = 16'ha5c3
) (
    // Link
    input wire logic sck,
    input wire logic spi_cs_n,
    input wire logic dsi_cs_n,
    output logic miso
);
    logic [15:0] sh_r;
    wire sel = !spi_cs_n || !dsi_cs_n;
    initial miso = 1'b0;
    always @(posedge sel) begin
        sh_r = ANSWER;
        miso = ANSWER[15];
    end
    always @(negedge sck) begin
        if (sel) begin
            sh_r = {sh_r[14:0], 1'b0};
            miso = sh_r[15];
        end
    end
    // A released line flips so that a stale bit never reads as valid.
    always @(negedge sel) miso = ~miso;
endmodule : csh_periph

// >>> test/tb_top.sv
// Self-checking bench for the combined serial controller.
// Assumes csh_ctrl is the top and csh_periph answers on the link.
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 6000) begin \
    @(negedge sys_clk); n++; end if (n >= 6000) fails++; end
module tb_top;
    logic sys_clk = 0, reset_n = 0, push_wr = 0, halt = 1, tc_irq_en = 0;
    logic tc_clr = 0, baud_clk = 0, miso, push_ready, running, tc_flag;
    logic tc_irq, rx_valid, sck, mosi, spi_cs_n, dsi_cs_n;
    logic [1:0] mode = csh_pkg::CSH_MODE_SPI_ONLY;
    logic [15:0] push_data = 16'h0000, dsi_data = 16'h3c5a, rx_data, cap;
    logic [15:0] spi_q[$], dsi_q[$];
    int fails = 0, check_count = 0, n, k;
    always #12.5 sys_clk = ~sys_clk;
    always #100 baud_clk = ~baud_clk;
    csh_ctrl dut (.sys_clk(sys_clk), .reset_n(reset_n), .push_wr(push_wr),
        .push_data(push_data), .push_ready(push_ready), .mode(mode),
        .halt(halt), .tc_irq_en(tc_irq_en), .dsi_data(dsi_data),
        .tc_clr(tc_clr), .running(running), .tc_flag(tc_flag),
        .tc_irq(tc_irq), .rx_data(rx_data), .rx_valid(rx_valid),
        .baud_clk(baud_clk), .miso(miso), .sck(sck), .mosi(mosi),
        .spi_cs_n(spi_cs_n), .dsi_cs_n(dsi_cs_n));
    csh_periph u_periph (.sck(sck), .spi_cs_n(spi_cs_n),
        .dsi_cs_n(dsi_cs_n), .miso(miso));
    always @(posedge sck) cap <= {cap[14:0], mosi};
    always @(posedge spi_cs_n) if (reset_n === 1'b1) spi_q.push_back(cap);
    always @(posedge dsi_cs_n) if (reset_n === 1'b1) dsi_q.push_back(cap);
    task automatic push(input logic [15:0] w);
        @(negedge sys_clk);
        push_wr = 1'b1;
        push_data = w;
        @(negedge sys_clk);
        push_wr = 1'b0;
    endtask : push
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #2ms;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        `CHK(running, 1'b0)
        push(16'hc001);
        push(16'h0b1e);
        `CHK(push_ready, 1'b0)
        push(16'hdead);
        halt = 1'b0;
        `WAITC(spi_q.size() == 2)
        `CHK(spi_q[0], 16'hc001)
        `CHK(spi_q[1], 16'h0b1e)
        `CHK(rx_data, 16'ha5c3)
        `CHK(tc_flag, 1'b1)
        repeat (600) @(negedge sys_clk);
        `CHK(spi_q.size(), 2)
        `CHK(dsi_q.size(), 0)
        mode = csh_pkg::CSH_MODE_COMBINED;
        `WAITC(dsi_q.size() == 2)
        `CHK(dsi_q[1], 16'h3c5a)
        `WAITC(dsi_cs_n === 1'b1)
        `WAITC(dsi_cs_n === 1'b0)
        k = dsi_q.size();
        tc_clr = 1'b1;
        tc_irq_en = 1'b1;
        halt = 1'b1;
        @(negedge sys_clk);
        tc_clr = 1'b0;
        repeat (35) @(posedge baud_clk);
        @(negedge sys_clk);
        `CHK(running, 1'b0)
        `CHK(dsi_q.size(), k + 1)
        `CHK(tc_irq, 1'b1)
        tc_clr = 1'b1;
        tc_irq_en = 1'b0;
        @(negedge sys_clk);
        tc_clr = 1'b0;
        @(negedge sys_clk);
        `CHK(tc_flag, 1'b0)
        `CHK(tc_irq, 1'b0)
        push(16'h7e57);
        halt = 1'b0;
        `WAITC(spi_q.size() == 3)
        `CHK(spi_q[2], 16'h7e57)
        // A push early in a deserial frame must wait for that frame to end.
        `WAITC(dsi_cs_n === 1'b0)
        k = dsi_q.size();
        push(16'h5a5a);
        `WAITC(spi_q.size() == 4)
        `CHK(spi_q[3], 16'h5a5a)
        `CHK(dsi_q.size(), k + 1)
        mode = csh_pkg::CSH_MODE_DSI_ONLY;
        push(16'hbeef);
        repeat (700) @(negedge sys_clk);
        `CHK(spi_q.size(), 4)
        give_verdict();
    end
endmodule : tb_top
